//--- pkg/sbm_map.svh
// Contract
// - After write address, master transmits until stop.
// - Stop ends a transfer unless a repeated start follows instead.
// - After read address, master receives slave data.
// - Register read uses repeated start after address.
// - Bus clock fixed at 62.5 kHz.
// - Slave holding clock low stretches the low phase.
// - Single master only, no arbitration or slave.
// - Shift mode has no start, stop or acknowledge.
// - Shift mode clock runs free, never stretched.
// - Mode bits 1:0 decode off/shift/two/three-wire.
// - Start generated only with start and protocol bits.
// - Stop generated only with stop and protocol bits.
// - Mode register write only, bits 7:4 unused.
// - Data register blocked while byte in progress.
// - Three-wire: data moves only while clock low.
// - Bytes shift most significant bit first.
// - Busy starts one byte, clears itself after.
// - No acknowledge driven on final received byte.
`ifndef SBM_MAP_SVH
`define SBM_MAP_SVH

// System clock and bus clock rates in Hz; the bus clock is 62.5 kHz.
`define SBM_SYS_HZ 20000000
`define SBM_BUS_HZ 62500
// Each bus bit is four quarter phases of the divider.
`define SBM_QTR_CYC (`SBM_SYS_HZ / (`SBM_BUS_HZ * 4))
`define SBM_QTR_W 7

// Register addresses.
`define SBM_ADDR_DATA 8'hCC
`define SBM_ADDR_MODE 8'hEB
`define SBM_ADDR_CTRL 8'hEC

// Mode register fields and reset value.
`define SBM_M_SEL 0
`define SBM_M_PROT 1
`define SBM_M_STOP 2
`define SBM_M_START 3
`define SBM_MODE_MSB 3
`define SBM_MODE_RST 4'h0
`define SBM_MODE_OFF 2'h0
`define SBM_MODE_STD 2'h1
`define SBM_MODE_I2C 2'h2
`define SBM_MODE_SBUS 2'h3

// Control register fields.
`define SBM_C_BUSY 0
`define SBM_C_TX 1
`define SBM_C_VFY 2
`define SBM_C_NACK 3

// Byte and phase geometry.
`define SBM_MSB 7
`define SBM_BIT_LAST 3'h7
`define SBM_PH_DATA 2'h0
`define SBM_PH_RISE 2'h1
`define SBM_PH_SAMP 2'h2
`define SBM_PH_FALL 2'h3
`define SBM_PIN_SCL 1
`define SBM_PIN_SDA 0
`define SBM_SYNC_W 2

`endif

//--- pkg/sbm_pkg.sv
`include "sbm_map.svh"

package sbm_pkg;
    typedef logic [7:0] sbm_byte_t;

    typedef enum logic [2:0] {
        st_idle,
        st_start,
        st_bit,
        st_ack,
        st_stop
    } sbm_state_t;

    // Whole state of the serial engine and its register file.
    typedef struct packed {
        sbm_state_t st;
        logic [1:0] ph;
        logic [2:0] bitcnt;
        sbm_byte_t shift;
        logic [`SBM_MODE_MSB:0] mode;
        logic tx;
        logic busy;
        logic nack;
        logic vfy;
        logic held;
        logic scl_dn;
        logic sda_dn;
        logic sen_dn;
        sbm_byte_t rdata;
    } sbm_core_t;

    typedef struct packed {
        logic [`SBM_QTR_W-1:0] cnt;
        logic tick;
    } sbm_div_t;

    typedef struct packed {
        logic [`SBM_SYNC_W-1:0] s1;
        logic [`SBM_SYNC_W-1:0] s2;
    } sbm_sync_t;
endpackage : sbm_pkg

//--- design/sbm_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbm_map.svh"

module sbm_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`SBM_SYNC_W-1:0] pin_in,
    output logic [`SBM_SYNC_W-1:0] pin_sync
);
    import sbm_pkg::*;

    sbm_sync_t q, d;

    // Two stages per pin; the first stage feeds only the second.
    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
    end

    // Released open-drain lines idle high, so reset to ones.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '1;
        end else begin
            q <= d;
        end
    end

    assign pin_sync = q.s2;
endmodule : sbm_sync
`default_nettype wire

//--- design/sbm_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbm_map.svh"

module sbm_clkdiv (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    output logic tick
);
    import sbm_pkg::*;

    sbm_div_t q, d;

    // Quarter-bit enable; held at zero while idle so every byte
    // starts on a full quarter and the bus rate never drifts.
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = '0;
        end else if (q.cnt == `SBM_QTR_W'(`SBM_QTR_CYC - 1)) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + `SBM_QTR_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule : sbm_clkdiv
`default_nettype wire

//--- design/sbm_serial_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbm_map.svh"

module sbm_serial_master (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire sbm_pkg::sbm_byte_t reg_addr,
    input wire sbm_pkg::sbm_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output sbm_pkg::sbm_byte_t reg_rdata,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic enable_line_o,
    output logic enable_line_oe
);
    import sbm_pkg::*;

    sbm_core_t q, d;
    logic tick;
    logic [`SBM_SYNC_W-1:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic bus_m;
    logic sbus_m;
    logic adv;
    logic last_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and the quarter-bit divider.

    // The clock and data lines are read back through two flip-flops; the enable line is not.
    sbm_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in({scl_i, sda_i}),
        .pin_sync(pin_s)
    );

    // The divider runs only while a byte is being moved.
    sbm_clkdiv u_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(q.st != st_idle),
        .tick(tick)
    );

    // Decoded views of the synchronised pins and the mode.
    assign scl_s = pin_s[`SBM_PIN_SCL];
    assign sda_s = pin_s[`SBM_PIN_SDA];
    assign bus_m = q.mode[`SBM_M_PROT];
    assign sbus_m = q.mode[`SBM_M_PROT] && q.mode[`SBM_M_SEL];
    assign last_bit = (q.bitcnt == `SBM_BIT_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: register file, then the bit engine.

    always_comb begin
        d = q;
        d.rdata = '0;
        adv = 1'b1;

        // Reads answer one cycle later; unmapped and write-only read zero.
        if (reg_rd) begin
            case (reg_addr)
                `SBM_ADDR_DATA: begin
                    if (!q.busy) begin
                        d.rdata = q.shift;
                    end
                end
                `SBM_ADDR_CTRL: begin
                    d.rdata[`SBM_C_BUSY] = q.busy;
                    d.rdata[`SBM_C_TX] = q.tx;
                    d.rdata[`SBM_C_VFY] = q.vfy;
                    d.rdata[`SBM_C_NACK] = q.nack;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end

        // Writes; the data register and control are frozen while busy.
        if (reg_wr) begin
            case (reg_addr)
                `SBM_ADDR_DATA: begin
                    if (!q.busy) begin
                        d.shift = reg_wdata;
                    end
                end
                `SBM_ADDR_MODE: begin
                    d.mode = reg_wdata[`SBM_MODE_MSB:0];
                end
                `SBM_ADDR_CTRL: begin
                    if (!q.busy) begin
                        d.tx = reg_wdata[`SBM_C_TX];
                        if (reg_wdata[`SBM_C_BUSY] && q.mode[1:0] != `SBM_MODE_OFF) begin
                            d.busy = 1'b1;
                            d.nack = 1'b0;
                            d.vfy = 1'b1;
                            d.ph = `SBM_PH_DATA;
                            d.bitcnt = '0;
                            // A start is only framed when the protocol bit is set.
                            if (q.mode[`SBM_M_START] && bus_m) begin
                                d.st = st_start;
                            end else begin
                                d.st = st_bit;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Bit engine, advanced once per quarter bit.
        if (tick) begin
            case (q.st)
                st_start: begin
                    case (q.ph)
                        `SBM_PH_DATA: begin
                            d.sda_dn = 1'b0;
                            d.sen_dn = 1'b0;
                        end
                        `SBM_PH_RISE: begin
                            d.scl_dn = 1'b0;
                        end
                        `SBM_PH_SAMP: begin
                            // A slow slave may keep the clock low; wait for it.
                            if (!scl_s) begin
                                adv = 1'b0;
                            end else if (sbus_m) begin
                                d.sen_dn = 1'b1;
                            end else begin
                                d.sda_dn = 1'b1;
                            end
                        end
                        default: begin
                            d.scl_dn = 1'b1;
                            d.sen_dn = 1'b0;
                            d.st = st_bit;
                        end
                    endcase
                end
                st_bit: begin
                    case (q.ph)
                        `SBM_PH_DATA: begin
                            // Data moves here, in the same cycle that pulls or keeps the clock low, and in shift mode is also released after the last bit.
                            d.scl_dn = 1'b1;
                            d.sda_dn = q.tx ? !q.shift[`SBM_MSB] : 1'b0;
                        end
                        `SBM_PH_RISE: begin
                            d.scl_dn = 1'b0;
                        end
                        `SBM_PH_SAMP: begin
                            if (bus_m && !scl_s) begin
                                adv = 1'b0;
                            end else begin
                                d.shift = {q.shift[`SBM_MSB-1:0], sda_s};
                                if (q.tx && bus_m && (sda_s == q.sda_dn)) begin
                                    d.vfy = 1'b0;
                                end
                            end
                        end
                        default: begin
                            // Shift mode leaves the clock high after its last bit.
                            d.scl_dn = !(last_bit && !bus_m);
                            d.bitcnt = q.bitcnt + 3'h1;
                            if (last_bit && bus_m) begin
                                d.st = st_ack;
                            end else if (last_bit) begin
                                d.sda_dn = 1'b0;
                                d.busy = 1'b0;
                                d.st = st_idle;
                            end
                        end
                    endcase
                end
                st_ack: begin
                    case (q.ph)
                        `SBM_PH_DATA: begin
                            // Receiver acks unless this is the final byte.
                            d.sda_dn = !q.tx && !q.mode[`SBM_M_STOP];
                        end
                        `SBM_PH_RISE: begin
                            d.scl_dn = 1'b0;
                        end
                        `SBM_PH_SAMP: begin
                            if (!scl_s) begin
                                adv = 1'b0;
                            end else if (q.tx) begin
                                d.nack = sda_s;
                            end
                        end
                        default: begin
                            d.scl_dn = 1'b1;
                            if (q.mode[`SBM_M_STOP]) begin
                                d.st = st_stop;
                            end else begin
                                // Bus stays owned with the clock low for the next byte.
                                d.held = 1'b1;
                                d.busy = 1'b0;
                                d.st = st_idle;
                            end
                        end
                    endcase
                end
                st_stop: begin
                    case (q.ph)
                        `SBM_PH_DATA: begin
                            d.sda_dn = !sbus_m;
                            d.sen_dn = sbus_m;
                        end
                        `SBM_PH_RISE: begin
                            d.scl_dn = 1'b0;
                        end
                        `SBM_PH_SAMP: begin
                            if (!scl_s) begin
                                adv = 1'b0;
                            end else begin
                                d.sda_dn = 1'b0;
                                d.sen_dn = 1'b0;
                            end
                        end
                        default: begin
                            // Busy drops only once the stop has fully completed.
                            d.held = 1'b0;
                            d.busy = 1'b0;
                            d.st = st_idle;
                        end
                    endcase
                end
                default: begin
                    adv = 1'b0;
                end
            endcase
            if (adv && q.st != st_idle) begin
                d.ph = q.ph + 2'h1;
            end
        end

        // The enable line is only ever driven in three-wire mode.
        if (d.mode[1:0] != `SBM_MODE_SBUS) begin
            d.sen_dn = 1'b0;
        end

        // Disabled mode drops any byte and releases every line.
        if (d.mode[1:0] == `SBM_MODE_OFF) begin
            d.st = st_idle;
            d.busy = 1'b0;
            d.held = 1'b0;
            d.scl_dn = 1'b0;
            d.sda_dn = 1'b0;
            d.sen_dn = 1'b0;
        end
    end

    // Shift data is left unknown-free but unspecified by software contract.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
            q.mode <= `SBM_MODE_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; open-drain lines only ever pull low, never drive high.

    assign reg_rdata = q.rdata;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign enable_line_o = 1'b0;
    assign scl_oe = q.scl_dn;
    assign sda_oe = q.sda_dn;
    assign enable_line_oe = q.sen_dn;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_off_released;
        q.mode[1:0] == `SBM_MODE_OFF |-> !scl_oe && !sda_oe && !enable_line_oe;
    endproperty
    a_off_released: assert property (p_off_released)
        else $error("Disabled interface drives a line.");

    property p_idle_clock_high;
        q.st == st_idle && !q.held |-> !scl_oe;
    endproperty
    a_idle_clock_high: assert property (p_idle_clock_high)
        else $error("Clock line pulled low while idle.");

    property p_start_gate;
        $rose(q.busy) |-> q.st == ((q.mode[`SBM_M_START] && bus_m) ? st_start : st_bit);
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("Start framing does not follow the mode bits.");

    property p_busy_idle;
        $fell(q.busy) |-> q.st == st_idle && q.ph == `SBM_PH_DATA || q.mode[1:0] == `SBM_MODE_OFF;
    endproperty
    a_busy_idle: assert property (p_busy_idle)
        else $error("Busy cleared before the byte finished.");

    property p_data_read_blocked;
        reg_rd && reg_addr == `SBM_ADDR_DATA && q.busy |=> reg_rdata == '0;
    endproperty
    a_data_read_blocked: assert property (p_data_read_blocked)
        else $error("Shift data readable while busy.");

    property p_data_write_blocked;
        reg_wr && reg_addr == `SBM_ADDR_DATA && q.busy && !tick |=> $stable(q.shift);
    endproperty
    a_data_write_blocked: assert property (p_data_write_blocked)
        else $error("Shift data written while busy.");

    property p_std_no_ack;
        q.mode[1:0] == `SBM_MODE_STD && q.st == st_bit && last_bit
            && q.ph == `SBM_PH_FALL && tick |=> q.st == st_idle && !q.busy;
    endproperty
    a_std_no_ack: assert property (p_std_no_ack)
        else $error("Shift mode went on past the eighth bit.");

    property p_std_free_clock;
        q.mode[1:0] == `SBM_MODE_STD && q.st == st_bit
            && q.ph == `SBM_PH_SAMP && tick |=> q.ph == `SBM_PH_FALL;
    endproperty
    a_std_free_clock: assert property (p_std_free_clock)
        else $error("Shift mode clock was held.");

    property p_stretch;
        bus_m && q.st == st_bit && q.ph == `SBM_PH_SAMP && tick && !scl_s
            |=> q.ph == `SBM_PH_SAMP && !scl_oe;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("Master ran on while the slave held the clock.");

    property p_data_steady;
        q.st == st_bit && !q.scl_dn && !$past(q.scl_dn) |-> $stable(q.sda_dn);
    endproperty
    a_data_steady: assert property (p_data_steady)
        else $error("Data line moved while the clock was high.");

    property p_msb_first;
        q.st == st_bit && q.ph == `SBM_PH_RISE && q.tx |-> q.sda_dn == !q.shift[`SBM_MSB];
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("Transmitted bit is not the shift register top bit.");

    property p_last_no_ack;
        q.st == st_ack && !q.tx && q.mode[`SBM_M_STOP] |-> !sda_oe;
    endproperty
    a_last_no_ack: assert property (p_last_no_ack)
        else $error("Acknowledge driven on the final received byte.");

    property p_two_wire_enable;
        q.mode[1:0] == `SBM_MODE_I2C |-> !enable_line_oe;
    endproperty
    a_two_wire_enable: assert property (p_two_wire_enable)
        else $error("Enable line driven in two-wire mode.");

    c_std_byte: cover property (q.mode[1:0] == `SBM_MODE_STD && $fell(q.busy));
    c_stop_done: cover property (q.st == st_stop && tick && q.ph == `SBM_PH_FALL);
    c_stretch: cover property (bus_m && q.ph == `SBM_PH_SAMP && tick && !scl_s);
    c_repeat_start: cover property ($rose(q.busy) && q.held && q.st == st_start);
endmodule : sbm_serial_master
`default_nettype wire

//--- tb/sbm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module sbm_slave_model #(
    parameter logic [7:0] RD_BYTE = 8'h96
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch,
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output logic mack
);
    int cnt = 0;
    logic act = 1'b0;
    logic rd = 1'b0;
    logic first = 1'b0;
    logic [7:0] sh = 8'h00;

    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        rx_byte = 8'h00;
        mack = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // The 1 ns wait lets a clock edge in the same step settle first.
    always @(negedge sda) begin
        #1;
        if (scl) begin
            act = 1'b1;
            rd = 1'b0;
            first = 1'b1;
            cnt = 0;
        end
    end

    // A rising data line under a high clock ends the frame.
    always @(posedge sda) begin
        #1;
        if (scl) begin
            act = 1'b0;
            rd = 1'b0;
            sda_oe = 1'b0;
        end
    end

    // Bits are taken on the rising clock, the first one is the top bit.
    always @(posedge scl) begin
        if (act && cnt < 8) begin
            sh = {sh[6:0], sda};
            cnt++;
            if (cnt == 8) rx_byte = sh;
        end else if (act) begin
            mack = !sda;
            cnt = 9;
        end
    end

    // Acknowledge and read data are set up while the clock is low.
    always @(negedge scl) begin
        if (act && cnt == 8) begin
            sda_oe = !rd;
            if (first) rd = sh[0];
            first = 1'b0;
        end else if (act && cnt == 9) begin
            cnt = 0;
            sda_oe = rd & !RD_BYTE[7];
        end else if (act && rd) begin
            sda_oe = !RD_BYTE[7 - cnt];
        end
        // Held past the master's sample quarter, and released off a clock edge.
        if (stretch) begin
            scl_oe = 1'b1;
            #14010;
            scl_oe = 1'b0;
        end
    end
endmodule : sbm_slave_model

`default_nettype wire

//--- tb/sbm_serial_master_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbm_map.svh"

module sbm_serial_master_tb_top;
    logic clk_sys, rst_n, reg_wr, reg_rd, stretch;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rx, v, wsh;
    logic scl_oe, sda_oe, enable_line_oe, m_scl_oe, m_sda_oe, mack, scl_o, sda_o, en_o;
    logic ps = 1'b1;
    logic pd = 1'b1;
    logic pe = 1'b1;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0, last = 0, per = 0, n_rise = 0, n_start = 0, n_est = 0, n_estop = 0, n_chg = 0;
    int n, n0, n1, s, r, e0, e1, c;
    wire scl_w = !(scl_oe | m_scl_oe);
    wire sda_w = !(sda_oe | m_sda_oe);
    wire en_w = !enable_line_oe;

    sbm_serial_master u_sbm_serial_master (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .enable_line_o(en_o),
        .enable_line_oe(enable_line_oe));

    sbm_slave_model u_sbm_slave_model (.scl(scl_w), .sda(sda_w & en_w), .stretch(stretch),
        .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte(rx), .mack(mack));

    ////////////////////////////////////////////////////////////////
    // Clock at 20 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Line watcher: clock period, starts and data moves under a high clock.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (scl_w && !ps) begin
            n_rise <= n_rise + 1;
            wsh <= {wsh[6:0], sda_w};
            per <= cyc - last;
            last <= cyc;
        end
        if (scl_w && ps) begin
            if (!sda_w && pd) n_start <= n_start + 1;
            if (sda_w != pd) n_chg <= n_chg + 1;
            if (!en_w && pe) n_est <= n_est + 1;
            if (en_w && !pe) n_estop <= n_estop + 1;
        end
        ps <= scl_w;
        pd <= sda_w;
        pe <= en_w;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data are only valid in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : rd

    // Polling is bounded so a stuck busy flag cannot hang the run.
    task automatic wait_done(output int k);
        logic [7:0] b;
        k = 0;
        do begin
            rd(`SBM_ADDR_CTRL, b);
            k++;
        end while (b[0] !== 1'b0 && k < 3000);
        chk({7'h0, k < 3000}, 8'h01);
    endtask : wait_done

    task automatic xfer(input logic [7:0] m, input logic [7:0] d, input logic [7:0] t,
                        output int k);
        wr(`SBM_ADDR_MODE, m);
        wr(`SBM_ADDR_DATA, d);
        wr(`SBM_ADDR_CTRL, t);
        wait_done(k);
    endtask : xfer

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // The tests need about 25000 cycles; this leaves a wide margin.
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        stretch = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`SBM_ADDR_CTRL, v); chk(v, 8'h00);
        rd(`SBM_ADDR_MODE, v); chk(v, 8'h00);
        rd(8'h10, v); chk(v, 8'h00);
        chk({6'h0, scl_w, sda_w}, 8'h03);
        chk({5'h0, scl_o, sda_o, en_o}, 8'h00);
        wr(`SBM_ADDR_DATA, 8'hA4);
        // Busy is refused while disabled, but the direction bit is still taken.
        wr(`SBM_ADDR_CTRL, 8'h03);
        rd(`SBM_ADDR_CTRL, v); chk(v, 8'h02);
        rd(`SBM_ADDR_DATA, v); chk(v, 8'hA4);
        // Address byte with start; the data register is shut while busy.
        wr(`SBM_ADDR_MODE, 8'h0A);
        wr(`SBM_ADDR_CTRL, 8'h03);
        wr(`SBM_ADDR_DATA, 8'h55);
        rd(`SBM_ADDR_DATA, v); chk(v, 8'h00);
        wait_done(n);
        rd(`SBM_ADDR_CTRL, v); chk(v, 8'h06);
        chk(rx, 8'hA4);
        rd(`SBM_ADDR_DATA, v); chk(v, 8'hA4);
        // Register address, then a byte stretched by the slave.
        xfer(8'h02, 8'h07, 8'h03, n0); chk(rx, 8'h07);
        stretch <= 1'b1;
        xfer(8'h02, 8'h5A, 8'h03, n1); chk(rx, 8'h5A);
        stretch <= 1'b0;
        chk({7'h0, n1 > n0 + 40}, 8'h01);
        // Repeated start with read direction, then a final read byte.
        s = n_start;
        xfer(8'h0A, 8'hA5, 8'h03, n); chk(8'(n_start - s), 8'h01);
        xfer(8'h06, 8'h00, 8'h01, n);
        rd(`SBM_ADDR_DATA, v); chk(v, 8'h96);
        chk({7'h0, mack}, 8'h00);
        chk({6'h0, scl_w, sda_w}, 8'h03);
        // Shift protocol with the start bit set, which must be ignored.
        s = n_start;
        r = n_rise;
        xfer(8'h09, 8'hC3, 8'h03, n0); chk(wsh, 8'hC3);
        chk(8'(n_rise - r), 8'h08);
        chk(8'(n_start - s), 8'h00);
        stretch <= 1'b1;
        xfer(8'h09, 8'hC3, 8'h03, n1);
        stretch <= 1'b0;
        chk({7'h0, (n1 <= n0 + 2) && (n0 <= n1 + 2)}, 8'h01);
        // Three-wire byte framed by the enable line.
        e0 = n_est;
        e1 = n_estop;
        c = n_chg;
        xfer(8'h0F, 8'hA4, 8'h03, n);
        rd(`SBM_ADDR_CTRL, v); chk(v, 8'h06);
        chk(8'(n_est - e0), 8'h01);
        chk(8'(n_estop - e1), 8'h01);
        chk(8'(n_chg - c), 8'h00);
        chk(8'(per / 4), 8'h50);
        report_and_stop();
    end
endmodule : sbm_serial_master_tb_top

`default_nettype wire
